// *** hdl/exec_cfg.svh ***
// Offsets, field positions, encodings and reset values of the execute block
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

// APB register byte offsets
`define EXEC_ACC_OFFSET      8'h00
`define EXEC_STATUS_OFFSET   8'h04

// Status register field positions
`define EXEC_ST_CARRY        0
`define EXEC_ST_NIBBLE       1
`define EXEC_ST_ZERO         2
`define EXEC_ST_POWER_DOWN   3
`define EXEC_ST_EXPIRY       4
`define EXEC_ST_SLEEPING     5

// Reset values
`define EXEC_ACC_RESET       8'h00
`define EXEC_FLAG_RESET      1'b0
`define EXEC_PD_RESET        1'b1
`define EXEC_TO_RESET        1'b1

// Instruction encodings: return and sleep as 14-bit words, rotates and subtract as opcode prefixes; unused positions are zero
`define EXEC_OP_RETURN       14'h0008
`define EXEC_OP_SLEEP        14'h0063
`define EXEC_OP_ROT_LEFT     6'h0d
`define EXEC_OP_ROT_RIGHT    6'h0c
`define EXEC_OP_LIT_SUB      5'h1e

// Field positions inside an instruction word
`define EXEC_DEST_BIT        7

`endif

// *** hdl/exec_pkg.sv ***
// Types shared by the execute block
package exec_pkg;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_RET2  = 2'b01,
    ST_SLEEP = 2'b10
  } exec_state_e;

  typedef logic [7:0] byte_t;

endpackage

// *** hdl/exec_alu.sv ***
// Combinational rotate-through-carry and literal-minus-accumulator datapath
`timescale 1ns/1ps
`default_nettype none

module exec_alu (
  input  wire logic         i_rot_left,
  input  wire logic         i_carry,
  input  wire exec_pkg::byte_t i_file_data,
  input  wire exec_pkg::byte_t i_literal,
  input  wire exec_pkg::byte_t i_acc,
  output exec_pkg::byte_t   o_rot_result,
  output logic              o_rot_carry,
  output exec_pkg::byte_t   o_sub_result,
  output logic              o_sub_carry,
  output logic              o_sub_nibble,
  output logic              o_sub_zero
);
  import exec_pkg::*;

  logic [8:0] diff;
  logic [4:0] low_diff;

  always_comb begin
    if (i_rot_left) begin
      o_rot_result = {i_file_data[6:0], i_carry};
      o_rot_carry  = i_file_data[7];
    end else begin
      o_rot_result = {i_carry, i_file_data[7:1]};
      o_rot_carry  = i_file_data[0];
    end
  end

  // Literal taken as unsigned 0..255, borrow lands in bit 8
  assign diff         = {1'b0, i_literal} - {1'b0, i_acc};
  assign low_diff     = {1'b0, i_literal[3:0]} - {1'b0, i_acc[3:0]};
  assign o_sub_result = diff[7:0];
  assign o_sub_carry  = ~diff[8];
  assign o_sub_nibble = ~low_diff[4];
  assign o_sub_zero   = (diff[7:0] == 8'h00);

endmodule // exec_alu

`default_nettype wire

// *** hdl/exec_core.sv ***
// Execute stage for return, rotate, sleep and literal-minus-accumulator
`timescale 1ns/1ps
`default_nettype none
`include "exec_cfg.svh"

// How it works
// - Return pops stack, loads stack top into PC, two cycles, flags untouched.
// - Register instructions carry 7-bit file address and one destination bit.
// - Rotate destination 0 writes accumulator, 1 writes file register back.
// - Rotate left through carry: old carry into bit 0, bit 7 out.
// - Rotate right through carry: old carry into bit 7, bit 0 out.
// - Sleep clears power-down flag and sets expiry flag.
// - Sleep clears watchdog counter and its prescaler.
// - Sleep stops the oscillator and halts execution.
// - Literal minus accumulator, two's complement, result to accumulator.
// - Unused encoding bits are zero; literal is a full 8-bit value. Only return and sleep check this; subtract decode ignores bit 8.
module exec_core #(
  parameter int PC_WIDTH = 13
) (
  input  wire logic                i_sys_clk,
  input  wire logic                i_reset_n,
  // Instruction issue
  input  wire logic                i_instr_valid,
  input  wire logic [13:0]         i_instr,
  input  wire exec_pkg::byte_t     i_file_rdata,
  output logic                     o_instr_ready,
  // Stack and program counter
  input  wire logic [PC_WIDTH-1:0] i_stack_top,
  output logic                     o_stack_pop,
  output logic                     o_pc_load,
  output logic [PC_WIDTH-1:0]      o_pc,
  // File register write port
  output logic                     o_file_we,
  output logic [6:0]               o_file_addr,
  output exec_pkg::byte_t          o_file_wdata,
  // Watchdog and oscillator
  output logic                     o_wdt_clear,
  output logic                     o_osc_stop,
  input  wire logic                i_wake,
  // Core state
  output exec_pkg::byte_t          o_acc,
  output logic                     o_carry,
  output logic                     o_nibble_borrow_flag,
  output logic                     o_zero,
  output logic                     o_power_down_flag,
  output logic                     o_expiry_flag,
  // APB slave
  input  wire logic                i_psel,
  input  wire logic                i_penable,
  input  wire logic                i_pwrite,
  input  wire logic [7:0]          i_paddr,
  input  wire logic [31:0]         i_pwdata,
  output logic                     o_pready,
  output logic [31:0]              o_prdata,
  output logic                     o_pslverr
);
  import exec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  exec_state_e state_reg;
  logic        take;
  logic        is_return;
  logic        is_sleep;
  logic        is_rot_left;
  logic        is_rot_right;
  logic        is_rot;
  logic        is_sub;
  logic        dest_file;
  logic [6:0]  file_addr;
  byte_t       literal;

  assign take         = i_instr_valid && o_instr_ready;
  // Exact compare: unused positions must be zero
  assign is_return    = take && (i_instr == `EXEC_OP_RETURN);
  assign is_sleep     = take && (i_instr == `EXEC_OP_SLEEP);
  assign is_rot_left  = take && (i_instr[13:8] == `EXEC_OP_ROT_LEFT);
  assign is_rot_right = take && (i_instr[13:8] == `EXEC_OP_ROT_RIGHT);
  assign is_rot       = is_rot_left || is_rot_right;
  assign is_sub       = take && (i_instr[13:9] == `EXEC_OP_LIT_SUB);
  assign dest_file    = i_instr[`EXEC_DEST_BIT];
  assign file_addr    = i_instr[6:0];
  assign literal      = i_instr[7:0];

  byte_t rot_result;
  logic  rot_carry;
  byte_t sub_result;
  logic  sub_carry;
  logic  sub_nibble;
  logic  sub_zero;

  exec_alu u_alu (
    .i_rot_left   (is_rot_left),
    .i_carry      (o_carry),
    .i_file_data  (i_file_rdata),
    .i_literal    (literal),
    .i_acc        (o_acc),
    .o_rot_result (rot_result),
    .o_rot_carry  (rot_carry),
    .o_sub_result (sub_result),
    .o_sub_carry  (sub_carry),
    .o_sub_nibble (sub_nibble),
    .o_sub_zero   (sub_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wake input: three stages, a change counts when stages two and three agree

  logic [2:0] wake_sync_reg;
  logic       wake_level_reg;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_sync_reg <= 3'h0;
    end else begin
      wake_sync_reg <= {wake_sync_reg[1:0], i_wake};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_level_reg <= 1'b0;
    end else if (wake_sync_reg[1] == wake_sync_reg[2]) begin
      wake_level_reg <= wake_sync_reg[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  exec_state_e state_next;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (is_return) begin
          state_next = ST_RET2;
        end else if (is_sleep) begin
          state_next = ST_SLEEP;
        end
      end
      ST_RET2: begin
        state_next = ST_RUN;
      end
      ST_SLEEP: begin
        if (wake_level_reg) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Ready drops for the second return cycle and for all of sleep
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_instr_ready <= 1'b1;
      o_osc_stop    <= 1'b0;
    end else begin
      o_instr_ready <= (state_next == ST_RUN);
      o_osc_stop    <= (state_next == ST_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack, program counter, watchdog

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_stack_pop <= 1'b0;
      o_pc_load   <= 1'b0;
      o_pc        <= '0;
    end else begin
      o_stack_pop <= is_return;
      o_pc_load   <= is_return;
      if (is_return) begin
        o_pc <= i_stack_top;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wdt_clear <= 1'b0;
    end else begin
      o_wdt_clear <= is_sleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File register write-back

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_file_we    <= 1'b0;
      o_file_addr  <= 7'h00;
      o_file_wdata <= 8'h00;
    end else begin
      o_file_we <= is_rot && dest_file;
      if (is_rot && dest_file) begin
        o_file_addr  <= file_addr;
        o_file_wdata <= rot_result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and flags; an executing instruction wins over a bus write

  logic apb_wr;
  logic wr_acc;
  logic wr_status;

  // Write lands only on the access edge that also sees pready high
  assign apb_wr    = i_psel && i_penable && i_pwrite && o_pready;
  assign wr_acc    = apb_wr && (i_paddr == `EXEC_ACC_OFFSET);
  assign wr_status = apb_wr && (i_paddr == `EXEC_STATUS_OFFSET);

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_acc <= `EXEC_ACC_RESET;
    end else if (is_rot && !dest_file) begin
      o_acc <= rot_result;
    end else if (is_sub) begin
      o_acc <= sub_result;
    end else if (wr_acc) begin
      o_acc <= i_pwdata[7:0];
    end
  end

  // Rotates touch carry only; return and sleep touch none of these
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_carry              <= `EXEC_FLAG_RESET;
      o_nibble_borrow_flag <= `EXEC_FLAG_RESET;
      o_zero               <= `EXEC_FLAG_RESET;
    end else if (is_rot) begin
      o_carry <= rot_carry;
    end else if (is_sub) begin
      o_carry              <= sub_carry;
      o_nibble_borrow_flag <= sub_nibble;
      o_zero               <= sub_zero;
    end else if (wr_status) begin
      o_carry              <= i_pwdata[`EXEC_ST_CARRY];
      o_nibble_borrow_flag <= i_pwdata[`EXEC_ST_NIBBLE];
      o_zero               <= i_pwdata[`EXEC_ST_ZERO];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_power_down_flag <= `EXEC_PD_RESET;
      o_expiry_flag     <= `EXEC_TO_RESET;
    end else if (is_sleep) begin
      o_power_down_flag <= 1'b0;
      o_expiry_flag     <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: answer registered in the setup cycle, ready in the access cycle

  logic [31:0] status_word;

  always_comb begin
    status_word                        = 32'h0000_0000;
    status_word[`EXEC_ST_CARRY]        = o_carry;
    status_word[`EXEC_ST_NIBBLE]       = o_nibble_borrow_flag;
    status_word[`EXEC_ST_ZERO]         = o_zero;
    status_word[`EXEC_ST_POWER_DOWN]   = o_power_down_flag;
    status_word[`EXEC_ST_EXPIRY]       = o_expiry_flag;
    status_word[`EXEC_ST_SLEEPING]     = (state_reg == ST_SLEEP);
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      if (i_psel && !i_penable) begin
        if (i_paddr == `EXEC_ACC_OFFSET) begin
          o_prdata <= {24'h00_0000, o_acc};
        end else if (i_paddr == `EXEC_STATUS_OFFSET) begin
          o_prdata <= status_word;
        end else begin
          o_pslverr <= 1'b1;
        end
      end
    end
  end

endmodule // exec_core

`default_nettype wire

// *** testbench/exec_core_props.sv ***
// Port-level checker for the execute block
`timescale 1ns/1ps
`default_nettype none
`include "exec_cfg.svh"
module exec_core_props #(
  parameter int PC_WIDTH = 13
) (
  input wire logic                i_sys_clk,
  input wire logic                i_reset_n,
  input wire logic                i_instr_valid,
  input wire logic [13:0]         i_instr,
  input wire exec_pkg::byte_t     i_file_rdata,
  input wire logic                o_instr_ready,
  input wire logic [PC_WIDTH-1:0] i_stack_top,
  input wire logic                o_stack_pop,
  input wire logic                o_pc_load,
  input wire logic [PC_WIDTH-1:0] o_pc,
  input wire logic                o_file_we,
  input wire logic [6:0]          o_file_addr,
  input wire exec_pkg::byte_t     o_file_wdata,
  input wire logic                o_wdt_clear,
  input wire logic                o_osc_stop,
  input wire exec_pkg::byte_t     o_acc,
  input wire logic                o_carry,
  input wire logic                o_power_down_flag,
  input wire logic                o_expiry_flag,
  input wire logic                i_psel,
  input wire logic                i_penable,
  input wire logic                o_pready
);
  import exec_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  logic take;
  assign take = i_instr_valid && o_instr_ready;
  ////////////////////////////////////////////////////////////////////////
  sequence ret_s;
    take && i_instr == `EXEC_OP_RETURN;
  endsequence
  sequence ret_done_s;
    o_stack_pop && o_pc_load && !o_instr_ready ##1 o_instr_ready;
  endsequence
  sequence slp_s;
    take && i_instr == `EXEC_OP_SLEEP;
  endsequence
  sequence rot_s(logic [5:0] op, logic d);
    take && i_instr[13:8] == op && i_instr[7] == d;
  endsequence
  ret_step_a: assert property (ret_s |=> ret_done_s) else $error("return steps wrong");
  ret_pc_a: assert property (ret_s |=> o_pc == $past(i_stack_top) && o_carry == $past(o_carry))
    else $error("return target or flag wrong");
  sleep_flag_a: assert property (slp_s |=> !o_power_down_flag && o_expiry_flag) else $error("sleep flags");
  sleep_wdt_a: assert property (slp_s |=> o_wdt_clear ##1 !o_wdt_clear) else $error("watchdog clear");
  sleep_halt_a: assert property (slp_s |=> o_osc_stop && !o_instr_ready) else $error("no halt");
  rot_left_a: assert property (rot_s(`EXEC_OP_ROT_LEFT, 1'b0) |=>
    !o_file_we && o_carry == $past(i_file_rdata[7]) && o_acc == {$past(i_file_rdata[6:0]), $past(o_carry)})
    else $error("rotate left");
  rot_right_a: assert property (rot_s(`EXEC_OP_ROT_RIGHT, 1'b1) |=>
    o_file_we && o_acc == $past(o_acc) && o_file_addr == $past(i_instr[6:0]) && o_carry == $past(i_file_rdata[0])
    && o_file_wdata == {$past(o_carry), $past(i_file_rdata[7:1])}) else $error("rotate right");
  sub_acc_a: assert property (take && i_instr[13:9] == `EXEC_OP_LIT_SUB |=>
    o_acc == $past(i_instr[7:0]) - $past(o_acc) && o_carry == ($past(o_acc) <= $past(i_instr[7:0])))
    else $error("literal subtract");
  bus_ready_a: assert property (i_psel && !i_penable |=> o_pready) else $error("no bus answer");
endmodule // exec_core_props

bind exec_core exec_core_props #(.PC_WIDTH(PC_WIDTH)) props_i (
  .i_sys_clk, .i_reset_n, .i_instr_valid, .i_instr, .i_file_rdata, .o_instr_ready, .i_stack_top,
  .o_stack_pop, .o_pc_load, .o_pc, .o_file_we, .o_file_addr, .o_file_wdata, .o_wdt_clear, .o_osc_stop,
  .o_acc, .o_carry, .o_power_down_flag, .o_expiry_flag, .i_psel, .i_penable, .o_pready
);
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the execute block
`timescale 1ns/1ps
`default_nettype none
`include "exec_cfg.svh"
module tb;
  import exec_pkg::*;
  logic        i_sys_clk = 1'b0, i_reset_n = 1'b0, i_instr_valid = 1'b0, i_wake = 1'b0;
  logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [13:0] i_instr = 14'h0000;
  byte_t       i_file_rdata = 8'h00;
  logic [12:0] i_stack_top = 13'h0000;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h00000000;
  logic        o_instr_ready, o_stack_pop, o_pc_load, o_file_we, o_wdt_clear, o_osc_stop, o_carry;
  logic        o_nibble_borrow_flag, o_zero, o_power_down_flag, o_expiry_flag, o_pready, o_pslverr;
  logic [12:0] o_pc;
  logic [6:0]  o_file_addr;
  byte_t       o_file_wdata, o_acc;
  logic [31:0] o_prdata, rd;
  logic        err, m_c = 1'b0, m_nb = 1'b0, m_z = 1'b0, m_pd = 1'b1, m_exp = 1'b1;
  byte_t       m_acc = 8'h00;
  int          failures = 0, total_checks = 0, cycles = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  exec_core uut (
    .i_sys_clk, .i_reset_n, .i_instr_valid, .i_instr, .i_file_rdata, .o_instr_ready, .i_stack_top,
    .o_stack_pop, .o_pc_load, .o_pc, .o_file_we, .o_file_addr, .o_file_wdata, .o_wdt_clear, .o_osc_stop,
    .i_wake, .o_acc, .o_carry, .o_nibble_borrow_flag, .o_zero, .o_power_down_flag, .o_expiry_flag,
    .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic state_chk();
    chk({o_power_down_flag, o_expiry_flag, o_zero, o_nibble_borrow_flag, o_carry, o_acc},
        {m_pd, m_exp, m_z, m_nb, m_c, m_acc});
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    // Wait ends when pready is seen high, or at the bench timeout
    do begin
      @(posedge i_sys_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  // Operand data is scrambled once released so a late sample shows up
  task automatic issue(input logic [13:0] w, input byte_t f, input logic [12:0] t);
    @(posedge i_sys_clk);
    i_instr_valid <= 1'b1;
    i_instr <= w;
    i_file_rdata <= f;
    i_stack_top <= t;
    @(posedge i_sys_clk);
    i_instr_valid <= 1'b0;
    i_file_rdata <= ~f;
    i_stack_top <= ~t;
    @(negedge i_sys_clk);
  endtask
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [6:0] a;
    byte_t f, k, res;
    logic d, l, nc;
    logic [12:0] t;
    int n;
    n = $urandom(90664);
    repeat (2) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    apb(1'b0, `EXEC_STATUS_OFFSET, 32'h0);
    chk(rd, 32'h00000018);
    state_chk();
    m_acc = $urandom;
    apb(1'b1, `EXEC_ACC_OFFSET, {24'h0, m_acc});
    apb(1'b0, `EXEC_ACC_OFFSET, 32'h0);
    chk(rd, {24'h0, m_acc});
    k = $urandom;
    apb(1'b1, `EXEC_STATUS_OFFSET, {24'h0, k});
    {m_z, m_nb, m_c} = k[2:0];
    apb(1'b0, `EXEC_STATUS_OFFSET, 32'h0);
    chk(rd, {27'h0, m_exp, m_pd, m_z, m_nb, m_c});
    state_chk();
    apb(1'b1, 8'h0c, 32'hff);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    for (int i = 0; i < 60; i++) begin
      a = $urandom;
      f = $urandom;
      k = (i == 5) ? m_acc : 8'($urandom);
      d = $urandom;
      l = $urandom;
      if (i % 3 != 2) begin
        issue({l ? `EXEC_OP_ROT_LEFT : `EXEC_OP_ROT_RIGHT, d, a}, f, 13'h0);
        res = l ? {f[6:0], m_c} : {m_c, f[7:1]};
        nc = l ? f[7] : f[0];
        chk(o_file_we, d);
        if (d)
          chk({o_file_addr, o_file_wdata}, {a, res});
        else
          m_acc = res;
        m_c = nc;
      end else begin
        issue({`EXEC_OP_LIT_SUB, 1'b0, k}, f, 13'h0);
        res = k - m_acc;
        m_c = (m_acc <= k);
        m_nb = (m_acc[3:0] <= k[3:0]);
        m_z = (res == 8'h00);
        m_acc = res;
      end
      state_chk();
    end
    repeat (2) begin
      t = $urandom;
      issue(`EXEC_OP_RETURN, 8'h00, t);
      chk({o_stack_pop, o_pc_load, o_instr_ready, o_pc}, {3'b110, t});
      @(negedge i_sys_clk);
      chk({o_stack_pop, o_instr_ready}, 2'b01);
    end
    // Stray bit in an unused position: must be consumed as a no-op
    issue(`EXEC_OP_RETURN | 14'h0100, 8'h00, 13'h0);
    chk({o_stack_pop, o_pc_load, o_instr_ready}, 3'b001);
    state_chk();
    issue(`EXEC_OP_SLEEP, 8'h00, 13'h0);
    m_pd = 1'b0;
    m_exp = 1'b1;
    chk({o_wdt_clear, o_osc_stop, o_instr_ready}, 3'b110);
    state_chk();
    issue({`EXEC_OP_LIT_SUB, 1'b0, 8'h5a}, 8'h00, 13'h0);
    state_chk();
    apb(1'b0, `EXEC_STATUS_OFFSET, 32'h0);
    chk(rd, {26'h0, 1'b1, m_exp, m_pd, m_z, m_nb, m_c});
    @(posedge i_sys_clk);
    i_wake <= 1'b1;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_instr_ready !== 1'b1 && n < 10);
    i_wake <= 1'b0;
    @(negedge i_sys_clk);
    chk({o_osc_stop, o_instr_ready, o_wdt_clear}, 3'b010);
    finish_test();
  end
endmodule // tb
`default_nettype wire
